/* hdl/pfc_regs.vh */
/*
  Constants of the parallel filter command decoder: command byte fields,
  special command codes, source and timing figures.
  Assumes a 100 MHz system clock.
*/
`ifndef PFC_REGS_VH
`define PFC_REGS_VH

// Filter command fields
`define PFC_POS_MSB 3
`define PFC_POS_LSB 0
`define PFC_SPD_MSB 6
`define PFC_SPD_LSB 4
`define PFC_WHEEL_BIT 7
`define PFC_POS_MAX 4'h9

// Special command codes
`define PFC_CMD_ONLINE 8'hee
`define PFC_CMD_BATCH 8'hdf
`define PFC_CMD_OPEN_A 8'haa
`define PFC_CMD_OPENC_A 8'hab
`define PFC_CMD_CLOSE_A 8'hac
`define PFC_CMD_OPEN_B 8'hba
`define PFC_CMD_OPENC_B 8'hbb
`define PFC_CMD_CLOSE_B 8'hbc

// Active source encoding
`define PFC_SRC_PAR 2'h0
`define PFC_SRC_SER 2'h1
`define PFC_SRC_LOC 2'h2

// Sample period
`define PFC_CLK_MHZ 100
`define PFC_SAMPLE_US 50
`define PFC_SAMPLE_CYC (`PFC_SAMPLE_US * `PFC_CLK_MHZ)

`endif

/* hdl/pfc_sync.v */
/*
  Two-stage synchroniser for a bus of asynchronous inputs.
  Assumes the inputs change freely with respect to clk.
*/
`timescale 1ns/1ps
module pfc_sync #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage1;

  // First stage is read only by the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule // pfc_sync

/* hdl/pfc_tick.v */
/*
  Periodic tick generator: one-cycle pulse every PERIOD cycles while run.
  Assumes PERIOD fits in 16 bits.
*/
`timescale 1ns/1ps
module pfc_tick #(
  parameter PERIOD = 5000
) (
  input wire clk,
  input wire rst_n,
  input wire run,
  output reg tick
);

  // Terminal count, cut to the counter's 16 bits on purpose
  localparam [31:0] LAST_FULL = PERIOD - 1;
  localparam [15:0] LAST = LAST_FULL[15:0];
  reg [15:0] count;

  // Counter restarts whenever sampling is stopped
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else if (count == LAST) begin
      count <= 16'h0000;
      tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule // pfc_tick

/* hdl/pfc_decoder.v */
/*
  Parallel filter command decoder, top level.
  Holds source selection, periodic sampling of the eight command lines,
  command classification, wheel dispatch, busy, error and interrupt logic,
  and a small register port for software.
  Assumes the command lines and keys are asynchronous pins; the wheel
  drives answer on the same clock with done and position-error levels.
*/
// Added by the designer: the plain strobed port and the placing of the registers.
// Overview of operation
// - After reset the parallel input is the active command source.
// - Pressing the on-line key selects the parallel input.
// - A qualifying parallel command selects parallel and updates the display; here only code 238 on a changed sample does so.
// - Parallel stays active until serial online command or local key.
// - Command is one strobeless byte on eight lines, read as one value.
// - Each byte is classified by pattern as filter or special command.
// - Position bits 3:0, speed bits 6:4, wheel select bit 7.
// - Positions 0 to 9 accepted; larger ignored unless a special code.
// - Speed is an unsigned value selecting speed zero to seven.
// - Wheel select 0 means wheel A, 1 means wheel B.
// - Position and speed go only to the selected wheel.
// - In remote mode the lines are sampled every fifty microseconds.
// - Move starts only on a changed sample with position 0 to 9; here a serial filter byte starts one on each valid pulse.
// - Position mismatch after a move starts recovery and flags error.
// - Changing from remote to local closes both shutters.
// - Code 238 on parallel forces remote mode with parallel source.
`timescale 1ns/1ps
`include "pfc_regs.vh"
module pfc_decoder #(
  parameter SAMPLE_CYC = `PFC_SAMPLE_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] cmd_lines,
  input wire online_key,
  input wire local_key,
  input wire shutter_toggle_key,
  input wire panel_wheel_b,
  input wire serial_cmd_valid,
  input wire [7:0] serial_cmd,
  output reg [3:0] wheel_a_pos,
  output reg [2:0] wheel_a_speed,
  output reg wheel_a_go,
  input wire wheel_a_done,
  input wire wheel_a_mismatch,
  output reg [3:0] wheel_b_pos,
  output reg [2:0] wheel_b_speed,
  output reg wheel_b_go,
  input wire wheel_b_done,
  input wire wheel_b_mismatch,
  output reg recover_a,
  output reg recover_b,
  output reg shutter_a_open,
  output reg shutter_b_open,
  output reg shutter_a_cond,
  output reg shutter_b_cond,
  output reg batch_seen,
  output reg [1:0] active_source,
  output reg display_update,
  output reg busy_line,
  output reg error_line,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output wire irq
);

  // Register indices
  localparam [3:0] ADDR_STATUS = 4'h0;
  localparam [3:0] ADDR_INT = 4'h1;
  localparam [3:0] ADDR_MASK = 4'h2;
  localparam [3:0] ADDR_LAST = 4'h3;

  // Interrupt bit positions
  localparam INT_CMD = 0;
  localparam INT_DONE = 1;
  localparam INT_ERR = 2;
  localparam INT_SRC = 3;

  // Classification results
  localparam [1:0] CLS_NONE = 2'h0;
  localparam [1:0] CLS_FILTER = 2'h1;
  localparam [1:0] CLS_SPECIAL = 2'h2;

  // Byte classification: special codes win over the filter reading
  function [1:0] classify;
    input [7:0] b;
    begin
      case (b)
        `PFC_CMD_ONLINE, `PFC_CMD_BATCH,
        `PFC_CMD_OPEN_A, `PFC_CMD_OPENC_A, `PFC_CMD_CLOSE_A,
        `PFC_CMD_OPEN_B, `PFC_CMD_OPENC_B, `PFC_CMD_CLOSE_B:
          classify = CLS_SPECIAL;
        default:
          if (b[`PFC_POS_MSB:`PFC_POS_LSB] <= `PFC_POS_MAX)
            classify = CLS_FILTER;
          else
            classify = CLS_NONE;
      endcase
    end
  endfunction

  wire [7:0] par_sync;
  wire [2:0] key_sync;
  wire tick;
  reg [7:0] prev_sample;
  reg [2:0] key_prev;
  reg busy_a;
  reg busy_b;
  reg [3:0] int_status;
  reg [3:0] int_mask;
  reg [3:0] int_set;

  wire remote = (active_source != `PFC_SRC_LOC);
  wire online_press = key_sync[0] & ~key_prev[0];
  wire local_press = key_sync[1] & ~key_prev[1];
  wire shut_press = key_sync[2] & ~key_prev[2];

  // Pins are asynchronous to clk
  pfc_sync #(.WIDTH(8)) u_par_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(cmd_lines),
    .dout(par_sync)
  );

  pfc_sync #(.WIDTH(3)) u_key_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({shutter_toggle_key, local_key, online_key}),
    .dout(key_sync)
  );

  // Sampling runs regardless of source so an online code still wakes us
  pfc_tick #(.PERIOD(SAMPLE_CYC)) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .run(1'b1),
    .tick(tick)
  );

  // Sample qualification
  wire par_change = tick & (par_sync != prev_sample);
  // Serial bytes need no change test; each valid pulse is a new byte
  wire par_online = par_change & (par_sync == `PFC_CMD_ONLINE);
  wire par_act = par_change & remote &
                 (active_source == `PFC_SRC_PAR);
  wire ser_act = serial_cmd_valid & (active_source == `PFC_SRC_SER);
  wire ser_online = serial_cmd_valid & (serial_cmd == `PFC_CMD_ONLINE);
  wire [7:0] cmd = par_act ? par_sync : serial_cmd;
  wire cmd_take = par_act | ser_act;
  wire [1:0] cmd_cls = classify(cmd);
  wire filt_take = cmd_take & (cmd_cls == CLS_FILTER);
  wire spec_take = cmd_take & (cmd_cls == CLS_SPECIAL);
  wire accepted = filt_take | spec_take;
  wire to_b = cmd[`PFC_WHEEL_BIT];
  wire [3:0] cmd_pos = cmd[`PFC_POS_MSB:`PFC_POS_LSB];
  wire [2:0] cmd_speed = cmd[`PFC_SPD_MSB:`PFC_SPD_LSB];
  wire done_a = busy_a & wheel_a_done;
  wire done_b = busy_b & wheel_b_done;
  wire err_a = done_a & wheel_a_mismatch;
  wire err_b = done_b & wheel_b_mismatch;

  // Previous sample tracks every tick, acted upon or not
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_sample <= 8'h00;
      key_prev <= 3'h0;
    end else begin
      key_prev <= key_sync;
      if (tick) begin
        prev_sample <= par_sync;
      end
    end
  end

  // Source selection; local key has priority over remote codes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_source <= `PFC_SRC_PAR;
      display_update <= 1'b0;
    end else begin
      display_update <= 1'b0;
      if (local_press) begin
        active_source <= `PFC_SRC_LOC;
        display_update <= 1'b1;
      end else if (online_press) begin
        active_source <= `PFC_SRC_PAR;
        display_update <= 1'b1;
      end else if (par_online) begin
        active_source <= `PFC_SRC_PAR;
        display_update <= 1'b1;
      end else if (ser_online) begin
        active_source <= `PFC_SRC_SER;
        display_update <= 1'b1;
      end
    end
  end

  // Wheel dispatch: only the selected wheel sees new values
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wheel_a_pos <= 4'h0;
      wheel_a_speed <= 3'h0;
      wheel_a_go <= 1'b0;
      wheel_b_pos <= 4'h0;
      wheel_b_speed <= 3'h0;
      wheel_b_go <= 1'b0;
    end else begin
      wheel_a_go <= 1'b0;
      wheel_b_go <= 1'b0;
      if (filt_take && !to_b) begin
        wheel_a_pos <= cmd_pos;
        wheel_a_speed <= cmd_speed;
        wheel_a_go <= 1'b1;
      end
      if (filt_take && to_b) begin
        wheel_b_pos <= cmd_pos;
        wheel_b_speed <= cmd_speed;
        wheel_b_go <= 1'b1;
      end
    end
  end

  // Busy per wheel; a new command wins over a done in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_a <= 1'b0;
      busy_b <= 1'b0;
      busy_line <= 1'b0;
    end else begin
      if (filt_take && !to_b)
        busy_a <= 1'b1;
      else if (done_a)
        busy_a <= 1'b0;
      if (filt_take && to_b)
        busy_b <= 1'b1;
      else if (done_b)
        busy_b <= 1'b0;
      busy_line <= (busy_a & ~done_a) | (busy_b & ~done_b) | filt_take;
    end
  end

  // Error and recovery pulses; error sticks until next accepted command
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      error_line <= 1'b0;
      recover_a <= 1'b0;
      recover_b <= 1'b0;
    end else begin
      recover_a <= err_a;
      recover_b <= err_b;
      if (err_a || err_b)
        error_line <= 1'b1;
      else if (accepted)
        error_line <= 1'b0;
    end
  end

  // Shutters: remote codes, local toggle, forced close on going local
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shutter_a_open <= 1'b0;
      shutter_b_open <= 1'b0;
      shutter_a_cond <= 1'b0;
      shutter_b_cond <= 1'b0;
      batch_seen <= 1'b0;
    end else begin
      batch_seen <= spec_take & (cmd == `PFC_CMD_BATCH);
      if (local_press && remote) begin
        shutter_a_open <= 1'b0;
        shutter_b_open <= 1'b0;
        shutter_a_cond <= 1'b0;
        shutter_b_cond <= 1'b0;
      end else if (!remote && shut_press) begin
        if (panel_wheel_b)
          shutter_b_open <= ~shutter_b_open;
        else
          shutter_a_open <= ~shutter_a_open;
      end else if (spec_take) begin
        case (cmd)
          `PFC_CMD_OPEN_A: begin
            shutter_a_open <= 1'b1;
            shutter_a_cond <= 1'b0;
          end
          `PFC_CMD_OPENC_A: begin
            shutter_a_open <= 1'b1;
            shutter_a_cond <= 1'b1;
          end
          `PFC_CMD_CLOSE_A: begin
            shutter_a_open <= 1'b0;
            shutter_a_cond <= 1'b0;
          end
          `PFC_CMD_OPEN_B: begin
            shutter_b_open <= 1'b1;
            shutter_b_cond <= 1'b0;
          end
          `PFC_CMD_OPENC_B: begin
            shutter_b_open <= 1'b1;
            shutter_b_cond <= 1'b1;
          end
          `PFC_CMD_CLOSE_B: begin
            shutter_b_open <= 1'b0;
            shutter_b_cond <= 1'b0;
          end
          default: begin
            shutter_a_open <= shutter_a_open;
          end
        endcase
      end
    end
  end

  // Interrupt sources
  always @* begin
    int_set = 4'h0;
    int_set[INT_CMD] = accepted;
    int_set[INT_DONE] = done_a | done_b;
    int_set[INT_ERR] = err_a | err_b;
    int_set[INT_SRC] = display_update;
  end

  // Sticky status, write one to clear; a new event beats the clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_status <= 4'h0;
      int_mask <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == ADDR_INT)
        int_status <= (int_status & ~reg_wdata[3:0]) | int_set;
      else
        int_status <= int_status | int_set;
      if (reg_wr && reg_addr == ADDR_MASK)
        int_mask <= reg_wdata[3:0];
    end
  end

  assign irq = |(int_status & int_mask);

  // Read port, data one cycle after the strobe; unmapped reads zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_STATUS: reg_rdata <= {2'h0, active_source, shutter_b_open,
                                   shutter_a_open, error_line, busy_line};
        ADDR_INT: reg_rdata <= {4'h0, int_status};
        ADDR_MASK: reg_rdata <= {4'h0, int_mask};
        ADDR_LAST: reg_rdata <= prev_sample;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // pfc_decoder

/* sim/pfc_chk.sv */
/*
  Checker for pfc_decoder: wheel dispatch, busy, error and source.
  Assumes one clock domain and a bind onto the decoder's ports.
*/
`timescale 1ns/1ps
module pfc_chk #(
  parameter SAMPLE_CYC = 20
) (
  input wire clk,
  input wire rst_n,
  input wire [3:0] wheel_a_pos,
  input wire wheel_a_go,
  input wire wheel_a_done,
  input wire wheel_a_mismatch,
  input wire [3:0] wheel_b_pos,
  input wire wheel_b_go,
  input wire wheel_b_done,
  input wire wheel_b_mismatch,
  input wire recover_a,
  input wire recover_b,
  input wire shutter_a_open,
  input wire shutter_b_open,
  input wire [1:0] active_source,
  input wire display_update,
  input wire busy_line,
  input wire error_line
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Dispatch rules
  a_go_one: assert property (!(wheel_a_go && wheel_b_go))
    else $error("both wheels started");
  a_pos_a_held: assert property ($changed(wheel_a_pos) |-> wheel_a_go)
    else $error("wheel a target moved without go");
  a_pos_a_range: assert property (wheel_a_go |-> wheel_a_pos <= 4'h9)
    else $error("wheel a position out of range");
  a_pos_b_range: assert property (wheel_b_go |-> wheel_b_pos <= 4'h9)
    else $error("wheel b position out of range");
  // Busy and error rules
  a_go_busy: assert property (wheel_b_go |-> busy_line ##1 !wheel_b_go)
    else $error("go without busy");
  a_busy_fall: assert property ($fell(busy_line) |->
    $past(wheel_a_done || wheel_b_done))
    else $error("busy fell without done");
  a_recov_cause: assert property ($rose(recover_b) |->
    $past(wheel_b_done && wheel_b_mismatch))
    else $error("recovery without mismatch");
  a_recov_err: assert property (recover_b |-> ##[0:1] error_line)
    else $error("recovery without error");
  // Source rules; shutters may close one cycle late
  a_local_shut: assert property (active_source == 2'h2 &&
    $past(active_source) != 2'h2 |->
    ##[0:1] (!shutter_a_open && !shutter_b_open))
    else $error("shutters open after local");
  a_src_disp: assert property ($changed(active_source) |->
    ##[0:1] display_update)
    else $error("source change not shown");
endmodule // pfc_chk
bind pfc_decoder pfc_chk #(.SAMPLE_CYC(SAMPLE_CYC)) pfc_chk_i (
  .clk(clk), .rst_n(rst_n), .wheel_a_pos(wheel_a_pos),
  .wheel_a_go(wheel_a_go), .wheel_a_done(wheel_a_done),
  .wheel_a_mismatch(wheel_a_mismatch), .wheel_b_pos(wheel_b_pos),
  .wheel_b_go(wheel_b_go), .wheel_b_done(wheel_b_done),
  .wheel_b_mismatch(wheel_b_mismatch), .recover_a(recover_a),
  .recover_b(recover_b), .shutter_a_open(shutter_a_open),
  .shutter_b_open(shutter_b_open), .active_source(active_source),
  .display_update(display_update), .busy_line(busy_line),
  .error_line(error_line));

/* sim/pfc_host.sv */
/*
  Host parallel port model: drives the eight command lines.
  Assumes the bench calls put and holds each byte a sample period.
*/
`timescale 1ns/1ps
module pfc_host (
  input wire clk,
  output reg [7:0] cmd_lines
);
  // Lines idle low until the first command
  initial begin
    cmd_lines = 8'h00;
  end
  // Bit 7 wheel, 6:4 speed, 3:0 position; no strobe, so all at once
  task put(input [7:0] b);
    begin
      @(posedge clk);
      cmd_lines <= b;
    end
  endtask
endmodule // pfc_host

/* sim/tb.sv */
/*
  Testbench for pfc_decoder: host model on the lines, keys, serial,
  wheel answers and register port driven here.
  Assumes SAMPLE_CYC of 20 to keep sample waits short.
*/
`timescale 1ns/1ps
module tb;
  localparam SC = 20;
  reg clk, rst_n, online_key, local_key, ser_v, reg_wr, reg_rd;
  reg shut_key, pnl, s_bat, s_disp;
  reg a_done, a_mm, b_done, b_mm;
  reg [7:0] ser_b, reg_wdata, d;
  reg [3:0] reg_addr;
  wire [7:0] cmd_lines, reg_rdata;
  wire [3:0] a_pos, b_pos;
  wire [2:0] a_spd, b_spd;
  wire [1:0] src;
  wire a_go, b_go, sa, sb, busy, err, irq;
  wire rec_a, rec_b, sa_c, sb_c, bat, disp;
  integer fails, n_tests;
  pfc_host pfc_host_i (.clk(clk), .cmd_lines(cmd_lines));
  pfc_decoder #(.SAMPLE_CYC(SC)) pfc_decoder_i (
    .clk(clk), .rst_n(rst_n), .cmd_lines(cmd_lines),
    .online_key(online_key), .local_key(local_key),
    .shutter_toggle_key(shut_key), .panel_wheel_b(pnl),
    .serial_cmd_valid(ser_v), .serial_cmd(ser_b),
    .wheel_a_pos(a_pos), .wheel_a_speed(a_spd), .wheel_a_go(a_go),
    .wheel_a_done(a_done), .wheel_a_mismatch(a_mm),
    .wheel_b_pos(b_pos), .wheel_b_speed(b_spd), .wheel_b_go(b_go),
    .wheel_b_done(b_done), .wheel_b_mismatch(b_mm),
    .recover_a(rec_a), .recover_b(rec_b), .shutter_a_open(sa),
    .shutter_b_open(sb), .shutter_a_cond(sa_c), .shutter_b_cond(sb_c),
    .batch_seen(bat), .active_source(src), .display_update(disp),
    .busy_line(busy), .error_line(err), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task conclude;
    begin
      if (fails == 0 && n_tests > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [7:0] g, input [7:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        $display("wrong value at %0t: got %h want %h", $time, g, e);
        fails = fails + 1;
      end
    end
  endtask
  // Register port: one-cycle strobes, read data in the next cycle
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  // Waits up to three sample periods plus five cycles; a missing expected go ends the run
  task wgo(input e);
    integer i;
    reg g;
    begin
      g = 1'b0;
      s_bat = 1'b0;
      s_disp = 1'b0;
      for (i = 0; i < 3 * SC + 5 && !g; i = i + 1) begin
        @(posedge clk);
        #1 g = (a_go === 1'b1) || (b_go === 1'b1);
        // One-cycle pulses are latched for checks after the wait
        if (bat === 1'b1)
          s_bat = 1'b1;
        if (disp === 1'b1)
          s_disp = 1'b1;
      end
      chk({7'h0, g}, {7'h0, e});
      if (e && !g)
        conclude;
    end
  endtask
  task done(input w, input m);
    begin
      @(posedge clk);
      a_done <= !w;
      b_done <= w;
      a_mm <= m;
      b_mm <= m;
      @(posedge clk);
      a_done <= 1'b0;
      b_done <= 1'b0;
      #1;
    end
  endtask
  // Keys pass a two-flop synchroniser, so hold them several cycles
  // Bit 0 online, bit 1 local, bit 2 shutter toggle
  task key(input [2:0] k);
    begin
      @(posedge clk);
      online_key <= k[0];
      local_key <= k[1];
      shut_key <= k[2];
      repeat (4) @(posedge clk);
      online_key <= 1'b0;
      local_key <= 1'b0;
      shut_key <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  task ser(input [7:0] b);
    begin
      @(posedge clk);
      ser_b <= b;
      ser_v <= 1'b1;
      @(posedge clk);
      ser_v <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  // Main sequence
  initial begin
    fails = 0;
    n_tests = 0;
    {rst_n, online_key, local_key, ser_v, reg_wr, reg_rd} = 6'h00;
    {a_done, a_mm, b_done, b_mm} = 4'h0;
    {shut_key, pnl} = 2'h0;
    ser_b = 8'h00;
    reg_wdata = 8'h00;
    reg_addr = 4'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({6'h0, src}, 8'h00);
    rd(4'h0);
    chk(d, 8'h00);
    wr(4'h2, 8'h02);
    pfc_host_i.put(8'h57);
    wgo(1'b1);
    chk({4'h0, a_pos}, 8'h07);
    chk({5'h0, a_spd}, 8'h05);
    chk({6'h0, a_go, b_go}, 8'h02);
    chk({7'h0, busy}, 8'h01);
    done(1'b0, 1'b0);
    chk({7'h0, busy}, 8'h00);
    chk({7'h0, irq}, 8'h01);
    rd(4'h1);
    chk(d, 8'h03);
    wr(4'h1, 8'h02);
    chk({7'h0, irq}, 8'h00);
    rd(4'h1);
    chk(d, 8'h01);
    rd(4'hf);
    chk(d, 8'h00);
    wr(4'h2, 8'h00);
    rd(4'h2);
    chk(d, 8'h00);
    wgo(1'b0);
    pfc_host_i.put(8'hfa);
    wgo(1'b0);
    pfc_host_i.put(8'hb3);
    wgo(1'b1);
    chk({3'h0, b_go, b_pos}, 8'h13);
    chk({5'h0, b_spd}, 8'h03);
    chk({4'h0, a_pos}, 8'h07);
    done(1'b1, 1'b1);
    chk({6'h0, rec_a, rec_b}, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk({7'h0, err}, 8'h01);
    pfc_host_i.put(8'h12);
    wgo(1'b1);
    chk({7'h0, err}, 8'h00);
    rd(4'h3);
    chk(d, 8'h12);
    done(1'b0, 1'b1);
    chk({6'h0, rec_a, rec_b}, 8'h02);
    chk({7'h0, err}, 8'h01);
    pfc_host_i.put(8'haa);
    wgo(1'b0);
    chk({7'h0, err}, 8'h00);
    pfc_host_i.put(8'hbb);
    wgo(1'b0);
    chk({4'h0, sb_c, sa_c, sb, sa}, 8'h0b);
    rd(4'h0);
    chk(d, 8'h0c);
    pfc_host_i.put(8'hdf);
    wgo(1'b0);
    chk({7'h0, s_bat}, 8'h01);
    key(3'h2);
    chk({2'h0, sb_c, sa_c, src, sb, sa}, 8'h08);
    pnl <= 1'b1;
    key(3'h4);
    chk({6'h0, sb, sa}, 8'h02);
    pfc_host_i.put(8'h05);
    wgo(1'b0);
    pfc_host_i.put(8'hee);
    wgo(1'b0);
    chk({6'h0, src}, 8'h00);
    chk({7'h0, s_disp}, 8'h01);
    ser(8'hee);
    chk({6'h0, src}, 8'h01);
    ser(8'h84);
    chk({1'h0, b_spd, b_pos}, 8'h04);
    chk({4'h0, a_pos}, 8'h02);
    chk({7'h0, busy}, 8'h01);
    done(1'b1, 1'b0);
    pfc_host_i.put(8'h06);
    wgo(1'b0);
    key(3'h1);
    chk({6'h0, src}, 8'h00);
    conclude;
  end
endmodule // tb
